// ===== core/edm_port.v
// External data memory port with bus hold; top of this block.
// Assumes core requests and pins are synchronous to clk_in.
// What this block does
// - Bank select low picks X space, high picks Y space.
// - Idle address bus keeps showing the last accessed address.
// - After reset the address bus shows all zeros until first access.
// - Data bus floats when not accessing and when bus granted away.
// - Bus owner strobe is low while this port uses the bus.
// - Hold grant goes low once the external master may use the bus.
// - While granted, bank, address and strobes float.
`timescale 1ns/1ps
`include "edm_map.vh"
module edm_port #(
  parameter AW = `EDM_ADDR_W,
  parameter DW = `EDM_DATA_W,
  parameter ACC_CYC = `EDM_ACC_CYC
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire req_in,
  input wire req_write_in,
  input wire req_bank_in,
  input wire [AW-1:0] req_addr_in,
  input wire [DW-1:0] req_wdata_in,
  output wire req_ready_out,
  output reg rd_valid_out,
  output reg [DW-1:0] rd_data_out,
  output wire bank_sel_out,
  output wire bank_sel_oe_out,
  output wire [AW-1:0] ext_address_bus_out,
  output wire ext_address_bus_oe_out,
  input wire [DW-1:0] ext_data_bus_in,
  output wire [DW-1:0] ext_data_bus_out,
  output wire ext_data_bus_oe_out,
  output wire mem_read_strobe_n_out,
  output wire mem_write_strobe_n_out,
  output wire mem_strobe_oe_out,
  input wire bus_hold_request_n_in,
  output wire bus_hold_grant_n_out,
  output wire bus_owner_strobe_n_out
);
  localparam ST_IDLE = 1'b0;
  localparam ST_ACC = 1'b1;
  localparam [7:0] CNT_ZERO = 8'h00;
  localparam [7:0] CNT_STEP = 8'h01;

  // Last count of an access; a zero cycle count still gives one cycle
  function [7:0] last_count;
    input integer cycles;
    integer span;
    begin
      span = cycles - 1;
      if (span < 0) begin
        span = 0;
      end
      last_count = span[7:0];
    end
  endfunction

  // Strobe level for one direction; high whenever that direction is idle
  function strobe_level_n;
    input acc_busy;
    input acc_write;
    input want_write;
    begin
      strobe_level_n = !(acc_busy && (acc_write == want_write));
    end
  endfunction

  localparam [7:0] CNT_LAST = last_count(ACC_CYC);

  // Access state
  reg state_reg;
  reg state_next;
  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;
  reg write_reg;
  reg write_next;

  // Held pin values
  reg bank_reg;
  reg bank_next;
  reg [AW-1:0] addr_reg;
  reg [AW-1:0] addr_next;
  reg [DW-1:0] wdata_reg;
  reg [DW-1:0] wdata_next;

  // Read return
  reg rd_valid_next;
  reg [DW-1:0] rd_data_next;

  // Pin strobes
  reg rd_strobe_n_reg;
  reg wr_strobe_n_reg;
  reg owner_n_reg;
  reg data_drive_reg;

  wire granted;
  wire busy;
  wire start;
  wire last_beat;
  wire busy_next;

  assign busy = (state_reg == ST_ACC);
  assign last_beat = busy && (cnt_reg == CNT_LAST);
  // No start while granted or a request is pending
  assign start = (state_reg == ST_IDLE) && req_in && !granted &&
    bus_hold_request_n_in;
  assign req_ready_out = start;
  assign busy_next = (state_next == ST_ACC);

  // Grant only from idle, so an access is never cut short
  edm_arbiter u_arb (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .hold_req_n_in(bus_hold_request_n_in),
    .busy_in(busy),
    .granted_out(granted)
  );

  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    write_next = write_reg;
    bank_next = bank_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rd_valid_next = 1'b0;
    rd_data_next = rd_data_out;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_ACC;
          cnt_next = CNT_ZERO;
          write_next = req_write_in;
          bank_next = req_bank_in;
          addr_next = req_addr_in;
          wdata_next = req_wdata_in;
        end
      end
      ST_ACC: begin
        if (last_beat) begin
          state_next = ST_IDLE;
          // Sample late, giving the memory its full access time
          if (!write_reg) begin
            rd_valid_next = 1'b1;
            rd_data_next = ext_data_bus_in;
          end
        end else begin
          cnt_next = cnt_reg + CNT_STEP;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Address held after access ends; cleared only by reset
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      cnt_reg <= CNT_ZERO;
      write_reg <= 1'b0;
      bank_reg <= `EDM_BANK_X;
      addr_reg <= `EDM_ADDR_RST;
      wdata_reg <= {DW{1'b0}};
      rd_valid_out <= 1'b0;
      rd_data_out <= {DW{1'b0}};
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      write_reg <= write_next;
      bank_reg <= bank_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rd_valid_out <= rd_valid_next;
      rd_data_out <= rd_data_next;
    end
  end

  // Strobes from the next state, so pins line up with busy glitch free
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_strobe_n_reg <= 1'b1;
      wr_strobe_n_reg <= 1'b1;
      owner_n_reg <= 1'b1;
      data_drive_reg <= 1'b0;
    end else begin
      rd_strobe_n_reg <= strobe_level_n(busy_next, write_next, 1'b0);
      wr_strobe_n_reg <= strobe_level_n(busy_next, write_next, 1'b1);
      owner_n_reg <= !busy_next;
      data_drive_reg <= busy_next && write_next;
    end
  end

  assign bank_sel_out = bank_reg;
  assign ext_address_bus_out = addr_reg;
  assign bank_sel_oe_out = !granted;
  assign ext_address_bus_oe_out = !granted;
  assign mem_strobe_oe_out = !granted;
  assign mem_read_strobe_n_out = rd_strobe_n_reg;
  assign mem_write_strobe_n_out = wr_strobe_n_reg;
  assign ext_data_bus_out = wdata_reg;
  // Grant never rises mid access, the grant term is a second guard
  assign ext_data_bus_oe_out = data_drive_reg && !granted;
  assign bus_owner_strobe_n_out = owner_n_reg;
  assign bus_hold_grant_n_out = !granted;
endmodule // edm_port

// ===== core/edm_map.vh
// Constants for the external data memory port.
// Assumes inclusion by core files only; no processes here.
`ifndef EDM_MAP_VH
`define EDM_MAP_VH
`define EDM_ADDR_W 13
`define EDM_DATA_W 16
`define EDM_ADDR_RST 13'h0000
`define EDM_BANK_X 1'b0
`define EDM_BANK_Y 1'b1
`define EDM_ACC_NS 8
`define EDM_ACC_CYC ((`EDM_ACC_NS + 3) / 4)
`endif

// ===== core/edm_arbiter.v
// Bus hold arbiter for the external data memory port.
// Assumes hold request is synchronous to clk_in and active low.
`timescale 1ns/1ps
`include "edm_map.vh"
module edm_arbiter (
  input wire clk_in,
  input wire rst_n_in,
  input wire hold_req_n_in,
  input wire busy_in,
  output wire granted_out
);
  reg granted_reg;
  reg granted_next;

  always @* begin
    granted_next = granted_reg;
    if (!hold_req_n_in && !busy_in) begin
      granted_next = 1'b1;
    end else if (hold_req_n_in) begin
      granted_next = 1'b0;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      granted_reg <= 1'b0;
    end else begin
      granted_reg <= granted_next;
    end
  end

  assign granted_out = granted_reg;
endmodule // edm_arbiter

// ===== verification/edm_mem.sv
// One-word external data memory beside edm_port.
// Assumes strobes come straight from the port pins.
`timescale 1ns/1ps
module edm_mem(input wire clk_in, mem_read_strobe_n_out, mem_write_strobe_n_out,
  input wire [15:0] ext_data_bus_out, output wire [15:0] ext_data_bus_in);
  reg [15:0] word_reg = 16'h0000;
  // Idle bus shows the inverse, so a stale word never matches
  assign ext_data_bus_in = mem_read_strobe_n_out ? ~word_reg : word_reg;
  always @(posedge clk_in) if (!mem_write_strobe_n_out) word_reg <= ext_data_bus_out;
endmodule // edm_mem

// ===== verification/edm_port_props.sv
// Pin checker for edm_port.
// Assumes the port's own clock and reset.
`timescale 1ns/1ps
module edm_props(input wire clk_in, rst_n_in, req_ready_out,
  ext_data_bus_oe_out, mem_strobe_oe_out, mem_read_strobe_n_out,
  mem_write_strobe_n_out, bus_hold_request_n_in, bus_hold_grant_n_out,
  bus_owner_strobe_n_out, input wire [12:0] ext_address_bus_out);
  wire g = !bus_hold_grant_n_out, o = !bus_owner_strobe_n_out;
  wire r = !mem_read_strobe_n_out, w = !mem_write_strobe_n_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  float_a: assert property (g |-> !mem_strobe_oe_out) else $error("float");
  data_oe_a: assert property (ext_data_bus_oe_out |-> w && !g)
    else $error("data oe");
  one_strobe_a: assert property (!(r && w)) else $error("strobes");
  owner_a: assert property (o == (r || w)) else $error("owner");
  addr_keep_a: assert property (!o && !$past(o) |->
    $stable(ext_address_bus_out)) else $error("addr");
  no_take_a: assert property (g |-> !req_ready_out) else $error("take");
  grant_a: assert property ($fell(bus_hold_request_n_in) |-> ##[1:6] g)
    else $error("grant");
  idle_a: assert property ($rose(g) |-> !$past(o)) else $error("busy");
  c_r: cover property (r);
  c_w: cover property (w);
  c_g: cover property (g);
endmodule // edm_props
bind edm_port edm_props u_edm_props(
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .req_ready_out(req_ready_out),
  .ext_data_bus_oe_out(ext_data_bus_oe_out),
  .mem_strobe_oe_out(mem_strobe_oe_out),
  .mem_read_strobe_n_out(mem_read_strobe_n_out),
  .mem_write_strobe_n_out(mem_write_strobe_n_out),
  .bus_hold_request_n_in(bus_hold_request_n_in),
  .bus_hold_grant_n_out(bus_hold_grant_n_out),
  .bus_owner_strobe_n_out(bus_owner_strobe_n_out),
  .ext_address_bus_out(ext_address_bus_out)
);

// ===== verification/testbench.sv
// Bench for edm_port with a one-word memory.
// Assumes edm_mem and edm_props are compiled first.
`timescale 1ns/1ps
module testbench;
  reg clk_in=0, rst_n_in=0, req_in=0, req_write_in=0, req_bank_in=0;
  reg bus_hold_request_n_in=1;
  reg [12:0] req_addr_in=0;
  reg [15:0] req_wdata_in=0;
  wire req_ready_out, rd_valid_out, bank_sel_out, bank_sel_oe_out;
  wire ext_address_bus_oe_out, ext_data_bus_oe_out, mem_strobe_oe_out;
  wire mem_read_strobe_n_out, mem_write_strobe_n_out;
  wire bus_hold_grant_n_out, bus_owner_strobe_n_out;
  wire [15:0] rd_data_out, ext_data_bus_in, ext_data_bus_out;
  wire [12:0] ext_address_bus_out;
  integer fails=0, total_checks=0;
  edm_port u_edm_port(
    .clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req_in),
    .req_write_in(req_write_in), .req_bank_in(req_bank_in),
    .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .bank_sel_out(bank_sel_out),
    .bank_sel_oe_out(bank_sel_oe_out),
    .ext_address_bus_out(ext_address_bus_out),
    .ext_address_bus_oe_out(ext_address_bus_oe_out),
    .ext_data_bus_in(ext_data_bus_in),
    .ext_data_bus_out(ext_data_bus_out),
    .ext_data_bus_oe_out(ext_data_bus_oe_out),
    .mem_read_strobe_n_out(mem_read_strobe_n_out),
    .mem_write_strobe_n_out(mem_write_strobe_n_out),
    .mem_strobe_oe_out(mem_strobe_oe_out),
    .bus_hold_request_n_in(bus_hold_request_n_in),
    .bus_hold_grant_n_out(bus_hold_grant_n_out),
    .bus_owner_strobe_n_out(bus_owner_strobe_n_out)
  );
  edm_mem u_edm_mem(
    .clk_in(clk_in),
    .mem_read_strobe_n_out(mem_read_strobe_n_out),
    .mem_write_strobe_n_out(mem_write_strobe_n_out),
    .ext_data_bus_out(ext_data_bus_out),
    .ext_data_bus_in(ext_data_bus_in)
  );
  initial forever #2 clk_in=~clk_in;
  task chk(input [15:0] s, e, input [31:0] n); begin
    total_checks=total_checks+1;
    if (s!==e) begin
      fails=fails+1;
      $display("mismatch %s exp %h saw %h",n,e,s);
    end
  end endtask
  // Bank follows address bit 0 so both banks get used
  task acc(input wr, input [12:0] a, input [15:0] d); begin
    @(negedge clk_in);
    {req_in,req_write_in,req_bank_in,req_addr_in,req_wdata_in}=
      {1'b1,wr,a[0],a,d};
    #1;
    while (req_ready_out!==1'b1) begin
      @(negedge clk_in);
      #1;
    end
    @(negedge clk_in);
    req_in=0;
    chk(bus_owner_strobe_n_out,0,"own");
    chk({mem_read_strobe_n_out,mem_write_strobe_n_out},{wr,!wr},"stb");
    repeat(2) @(negedge clk_in);
    chk(rd_valid_out,!wr,"vld");
    chk(bus_owner_strobe_n_out,1,"own");
    @(negedge clk_in);
  end endtask
  task t_late; begin
    @(negedge clk_in);
    {req_in,req_write_in,req_bank_in,req_addr_in}={1'b1,1'b0,1'b1,13'h0ABC};
    @(negedge clk_in);
    req_in=0;
    bus_hold_request_n_in=0;
    chk(bus_hold_grant_n_out,1,"erl");
    repeat(2) begin
      @(negedge clk_in);
      chk(bus_hold_grant_n_out,1,"erl");
    end
    @(negedge clk_in);
    chk(bus_hold_grant_n_out,0,"lgn");
    chk({bank_sel_out,ext_address_bus_out},14'h2ABC,"lad");
    bus_hold_request_n_in=1;
    repeat(2) @(negedge clk_in);
    chk(bus_hold_grant_n_out,1,"rel");
    $display("late hold test done");
  end endtask
  task t_rw; begin
    chk(ext_address_bus_out,0,"rst");
    acc(1,13'h1FFF,16'hA5C3);
    acc(0,13'h0002,0);
    chk(rd_data_out,16'hA5C3,"rd");
    chk({bank_sel_out,ext_address_bus_out},14'h0002,"adr");
    $display("rw test done");
  end endtask
  task t_hold; begin
    bus_hold_request_n_in=0;
    repeat(3) @(negedge clk_in);
    chk({bus_hold_grant_n_out,ext_data_bus_oe_out},0,"gnt");
    chk({bank_sel_oe_out,ext_address_bus_oe_out,mem_strobe_oe_out},0,"flt");
    req_in=1;
    repeat(3) begin
      @(negedge clk_in);
      chk(req_ready_out,0,"stl");
    end
    {req_in,bus_hold_request_n_in}=2'b01;
    acc(1,13'h1001,16'h5A3C);
    chk({bank_sel_oe_out,ext_address_bus_oe_out,mem_strobe_oe_out},7,"drv");
    acc(0,13'h1001,0);
    chk(rd_data_out,16'h5A3C,"rd2");
    $display("hold test done");
  end endtask
  task conclude; begin
    $display("checks %0d fails %0d",total_checks,fails);
    if (fails==0 && total_checks>0) $display("Test passed");
    else $display("Test failed");
    $finish;
  end endtask
  initial begin
    repeat(12) @(negedge clk_in);
    rst_n_in=1;
    t_rw;
    t_hold;
    t_late;
    conclude;
  end
  initial begin
    #2000;
    fails=fails+1;
    conclude;
  end
endmodule // testbench
